//--- src/ddrs_fifo.sv
`timescale 1ns/100ps
module ddrs_fifo #(
    parameter int W = 64,
    parameter int D = 11
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // fill side
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready,
    // status
    output logic o_full
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [PW-1:0] LAST = PW'(D - 1);
    localparam logic [CW-1:0] FULL = CW'(D);

    logic [W-1:0] mem_r [D];
    logic [W-1:0] mem_nxt [D];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign o_full = cnt_r == FULL;
    assign o_in_ready = !o_full;
    assign o_out_valid = cnt_r != '0;
    assign o_out_data = mem_r[rp_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // ==========================================================
    // pointers and storage
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = i_in_data;
            wp_nxt = (wp_r == LAST) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < D; i++) begin
                mem_r[i] <= '0;
            end
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

//--- src/ddrs_pkg.sv
package ddrs_pkg;
    // ==========================================================
    // sizes
    localparam int CQ_DEPTH = 7;
    localparam int WQ_DEPTH = 11;
    localparam int RQ_DEPTH = 17;
    localparam int NUM_MST = 4;
    localparam int NUM_BANK = 8;
    localparam int DATA_W = 64;
    // ==========================================================
    // address map
    localparam int ADDR_USED = 28;
    localparam int COL_LSB = 1;
    localparam int BASE_COL_BITS = 8;
    localparam int BLOCK_LSB = 11;
    localparam int ROW_BITS = 14;
    localparam int ROW_BITS_4B_MAXPG = 13;
    localparam int ROW_BITS_8B_MAXPG = 12;
    localparam logic [1:0] BANKS_1 = 2'h0;
    localparam logic [1:0] BANKS_2 = 2'h1;
    localparam logic [1:0] BANKS_4 = 2'h2;
    localparam logic [1:0] BANKS_8 = 2'h3;
    localparam logic [1:0] PAGE_256 = 2'h0;
    localparam logic [1:0] PAGE_512 = 2'h1;
    localparam logic [1:0] PAGE_1024 = 2'h2;
    localparam logic [1:0] PAGE_2048 = 2'h3;
    localparam logic [1:0] BE_BOTH = 2'h3;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_LOW = 2'h1;
    // ==========================================================
    // refresh urgency
    localparam logic [3:0] REF_MAY_LVL = 4'h0;
    localparam logic [3:0] REF_NEED_LVL = 4'h7;
    localparam logic [3:0] REF_MUST_LVL = 4'hB;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        DDRS_K_READ = 2'h0,
        DDRS_K_WRITE = 2'h1,
        DDRS_K_REF = 2'h3,
        DDRS_K_SELF = 2'h2
    } ddrs_kind_e;
    typedef enum logic [0:0] {
        DDRS_RUN = 1'h0,
        DDRS_SLEEP = 1'h1
    } ddrs_state_e;
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic [2:0] prio;
        logic [1:0] mst;
        logic half;
        logic to_reg;
    } ddrs_req_s;
    typedef struct packed {
        logic wr;
        logic [2:0] prio;
        logic [1:0] mst;
        logic [16:0] blk;
        logic [13:0] row;
        logic [2:0] bank;
        logic [10:0] col;
        logic [1:0] be;
    } ddrs_ent_s;
    typedef struct packed {
        ddrs_kind_e kind;
        logic [1:0] mst;
        logic [13:0] row;
        logic [2:0] bank;
        logic [10:0] col;
        logic [1:0] be;
        logic need_pre;
        logic need_act;
    } ddrs_issue_s;
endpackage

//--- src/ddrs_sched.sv
`timescale 1ns/100ps
// Operation
// - column from bit 1 up (bits 8:1 at page code 0), bank, row above
// - 14 row bits, 13 or 12 at max page with 4 or 8 banks
// - column advances with linear logical address
// - page end continues same row, next bank
// - at most one open page per bank
// - rows stay open after an access completes
// - command 7, write 11, read 17 deep
// - one bus carries commands, data, registers
// - oldest command of each master first
// - read passes write: other block, prio not lower
// - dma read and write ports separate masters
// - one ready command per master
// - prefer open-row reads and open-row writes
// - highest priority wins, oldest breaks ties
// - read first if read fifo has room and the picked write has no higher prio
// - refresh postponed as long as allowed
// - must, read, need, write, may, self-refresh
// - per-master order kept, same-block reads wait
// - bank count codes 0 to 3h
// - page codes 0 to 3h, 8-11 column bits
// - refresh urgency thresholds 0, 7, 11
// - address bit 0 drives byte enables
module ddrs_sched
    import ddrs_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // configuration
    input wire logic [1:0] i_internal_bank_count_sel,
    input wire logic [1:0] i_page_words_sel,
    input wire logic [3:0] i_ref_backlog,
    input wire logic i_sr_req,
    // command port
    input wire logic i_cmd_valid,
    input wire ddrs_pkg::ddrs_req_s i_cmd,
    output logic o_cmd_ready,
    // register access
    output logic o_reg_valid,
    output logic [31:0] o_reg_addr,
    output logic o_reg_wr,
    // write data in
    input wire logic i_wd_valid,
    input wire logic [ddrs_pkg::DATA_W-1:0] i_wd_data,
    output logic o_wd_ready,
    // write data to memory
    output logic o_mem_wd_valid,
    output logic [ddrs_pkg::DATA_W-1:0] o_mem_wd_data,
    input wire logic i_mem_wd_take,
    // read data from memory
    input wire logic i_mem_rd_valid,
    input wire logic [ddrs_pkg::DATA_W-1:0] i_mem_rd_data,
    output logic o_mem_rd_ready,
    // read data out
    output logic o_rd_valid,
    output logic [ddrs_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_rd_ready,
    // issued command
    output logic o_issue_valid,
    output ddrs_pkg::ddrs_issue_s o_issue,
    input wire logic i_issue_ready
);
    import ddrs_pkg::*;

    ddrs_ent_s cq_r [CQ_DEPTH];
    ddrs_ent_s cq_nxt [CQ_DEPTH];
    logic [2:0] cnt_r, cnt_nxt;
    ddrs_ent_s map_w;
    logic [CQ_DEPTH-1:0] elig_rd, elig_old, hit, cand;
    logic [NUM_MST-1:0] any_rd;
    logic older, okr;
    logic rd_v, wr_v, rd_hit_any, wr_hit_any;
    logic [2:0] rd_i, wr_i, sel_idx;
    logic must, need, may, rd_full, rd_ok;
    logic load, take_mem, push, dec_v;
    ddrs_issue_s dec, iss_r, iss_nxt;
    logic iss_v_r, iss_v_nxt;
    logic [NUM_BANK-1:0] open_v_r, open_v_nxt;
    logic [13:0] open_row_r [NUM_BANK];
    logic [13:0] open_row_nxt [NUM_BANK];
    ddrs_state_e st_r, st_nxt;
    logic reg_v_r, reg_v_nxt, reg_wr_r, reg_wr_nxt;
    logic [31:0] reg_a_r, reg_a_nxt;

    // ==========================================================
    // address map
    function automatic ddrs_ent_s map_req(ddrs_req_s r, logic [1:0] bsel, logic [1:0] psel);
        logic [27:0] a;
        logic [27:0] hw;
        int ncb;
        int nrb;
        ddrs_ent_s e;
        a = r.addr[ADDR_USED-1:0];
        ncb = BASE_COL_BITS + int'(psel);
        nrb = ROW_BITS;
        if (psel == PAGE_2048 && bsel == BANKS_8) begin
            nrb = ROW_BITS_8B_MAXPG;
        end else if (psel == PAGE_2048 && bsel == BANKS_4) begin
            nrb = ROW_BITS_4B_MAXPG;
        end
        hw = a >> COL_LSB;
        e.col = 11'(hw & ((28'h1 << ncb) - 28'h1));
        hw = hw >> ncb;
        e.bank = 3'(hw & ((28'h1 << bsel) - 28'h1));
        hw = hw >> bsel;
        e.row = 14'(hw & ((28'h1 << nrb) - 28'h1));
        e.blk = 17'(a >> BLOCK_LSB);
        e.be = r.half ? BE_BOTH : (a[0] ? BE_HIGH : BE_LOW);
        e.wr = r.wr;
        e.prio = r.prio;
        e.mst = r.mst;
        return e;
    endfunction

    assign map_w = map_req(i_cmd, i_internal_bank_count_sel, i_page_words_sel);

    // ==========================================================
    // data fifos
    ddrs_fifo #(.W(DATA_W), .D(WQ_DEPTH)) u_wq (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_wd_valid),
        .i_in_data(i_wd_data),
        .o_in_ready(o_wd_ready),
        .o_out_valid(o_mem_wd_valid),
        .o_out_data(o_mem_wd_data),
        .i_out_ready(i_mem_wd_take),
        .o_full()
    );

    ddrs_fifo #(.W(DATA_W), .D(RQ_DEPTH)) u_rq (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_mem_rd_valid),
        .i_in_data(i_mem_rd_data),
        .o_in_ready(o_mem_rd_ready),
        .o_out_valid(o_rd_valid),
        .o_out_data(o_rd_data),
        .i_out_ready(i_rd_ready),
        .o_full(rd_full)
    );

    // ==========================================================
    // per-master ordering
    always_comb begin
        older = 1'b0;
        okr = 1'b1;
        any_rd = '0;
        for (int i = 0; i < CQ_DEPTH; i++) begin
            older = 1'b0;
            okr = 1'b1;
            for (int j = 0; j < i; j++) begin
                if (cq_r[j].mst == cq_r[i].mst) begin
                    older = 1'b1;
                    if (!cq_r[j].wr) begin
                        okr = 1'b0;
                    end else if (cq_r[j].blk == cq_r[i].blk || cq_r[i].prio < cq_r[j].prio) begin
                        okr = 1'b0;
                    end
                end
            end
            elig_old[i] = (3'(i) < cnt_r) && !older;
            elig_rd[i] = (3'(i) < cnt_r) && !cq_r[i].wr && okr;
            hit[i] = open_v_r[cq_r[i].bank] && open_row_r[cq_r[i].bank] == cq_r[i].row;
            if (elig_rd[i]) begin
                any_rd[cq_r[i].mst] = 1'b1;
            end
        end
        for (int i = 0; i < CQ_DEPTH; i++) begin
            cand[i] = elig_rd[i] || (elig_old[i] && !any_rd[cq_r[i].mst]);
        end
    end

    // ==========================================================
    // cross-master pick
    always_comb begin
        rd_hit_any = 1'b0;
        wr_hit_any = 1'b0;
        rd_v = 1'b0;
        wr_v = 1'b0;
        rd_i = '0;
        wr_i = '0;
        for (int i = 0; i < CQ_DEPTH; i++) begin
            if (cand[i] && hit[i] && !cq_r[i].wr) begin
                rd_hit_any = 1'b1;
            end
            if (cand[i] && hit[i] && cq_r[i].wr) begin
                wr_hit_any = 1'b1;
            end
        end
        for (int i = 0; i < CQ_DEPTH; i++) begin
            if (cand[i] && !cq_r[i].wr && (hit[i] || !rd_hit_any)) begin
                if (!rd_v || cq_r[i].prio > cq_r[rd_i].prio) begin
                    rd_v = 1'b1;
                    rd_i = 3'(i);
                end
            end
            if (cand[i] && cq_r[i].wr && (hit[i] || !wr_hit_any)) begin
                if (!wr_v || cq_r[i].prio > cq_r[wr_i].prio) begin
                    wr_v = 1'b1;
                    wr_i = 3'(i);
                end
            end
        end
    end

    // ==========================================================
    // final arbitration
    assign may = i_ref_backlog > REF_MAY_LVL;
    assign need = i_ref_backlog > REF_NEED_LVL;
    assign must = i_ref_backlog > REF_MUST_LVL;
    assign rd_ok = rd_v && !rd_full && !(wr_v && cq_r[wr_i].prio > cq_r[rd_i].prio);
    assign load = !iss_v_r || i_issue_ready;

    always_comb begin
        dec = '0;
        dec_v = 1'b1;
        take_mem = 1'b0;
        sel_idx = '0;
        if (must) begin
            dec.kind = DDRS_K_REF;
        end else if (rd_ok) begin
            dec.kind = DDRS_K_READ;
            take_mem = 1'b1;
            sel_idx = rd_i;
        end else if (need) begin
            dec.kind = DDRS_K_REF;
        end else if (wr_v) begin
            dec.kind = DDRS_K_WRITE;
            take_mem = 1'b1;
            sel_idx = wr_i;
        end else if (may) begin
            dec.kind = DDRS_K_REF;
        end else if (i_sr_req && st_r == DDRS_RUN && cnt_r == '0) begin
            dec.kind = DDRS_K_SELF;
        end else begin
            dec_v = 1'b0;
        end
        if (take_mem) begin
            dec.mst = cq_r[sel_idx].mst;
            dec.row = cq_r[sel_idx].row;
            dec.bank = cq_r[sel_idx].bank;
            dec.col = cq_r[sel_idx].col;
            dec.be = cq_r[sel_idx].be;
            dec.need_pre = open_v_r[dec.bank] && !hit[sel_idx];
            dec.need_act = !hit[sel_idx];
        end
    end

    // ==========================================================
    // command queue, issue, open rows, state
    assign o_cmd_ready = i_cmd.to_reg || cnt_r < 3'(CQ_DEPTH);
    assign push = i_cmd_valid && o_cmd_ready && !i_cmd.to_reg;

    always_comb begin
        cq_nxt = cq_r;
        cnt_nxt = cnt_r;
        iss_v_nxt = iss_v_r;
        iss_nxt = iss_r;
        open_v_nxt = open_v_r;
        open_row_nxt = open_row_r;
        st_nxt = st_r;
        reg_v_nxt = i_cmd_valid && i_cmd.to_reg;
        reg_a_nxt = reg_v_nxt ? i_cmd.addr : reg_a_r;
        reg_wr_nxt = reg_v_nxt ? i_cmd.wr : reg_wr_r;
        if (load) begin
            iss_v_nxt = dec_v;
            iss_nxt = dec;
            if (dec_v && take_mem) begin
                for (int i = 0; i < CQ_DEPTH - 1; i++) begin
                    if (3'(i) >= sel_idx) begin
                        cq_nxt[i] = cq_r[i + 1];
                    end
                end
                cnt_nxt = cnt_r - 3'h1;
                open_v_nxt[dec.bank] = 1'b1;
                open_row_nxt[dec.bank] = dec.row;
            end else if (dec_v) begin
                open_v_nxt = '0;
            end
        end
        if (push) begin
            cq_nxt[cnt_nxt] = map_w;
            cnt_nxt = cnt_nxt + 3'h1;
        end
        case (st_r)
            DDRS_RUN: begin
                if (load && dec_v && dec.kind == DDRS_K_SELF) begin
                    st_nxt = DDRS_SLEEP;
                end
            end
            DDRS_SLEEP: begin
                if (cnt_r != '0 || !i_sr_req) begin
                    st_nxt = DDRS_RUN;
                end
            end
            default: begin
                st_nxt = DDRS_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < CQ_DEPTH; i++) begin
                cq_r[i] <= '0;
            end
            for (int i = 0; i < NUM_BANK; i++) begin
                open_row_r[i] <= '0;
            end
            cnt_r <= '0;
            iss_v_r <= 1'b0;
            iss_r <= '0;
            open_v_r <= '0;
            st_r <= DDRS_RUN;
            reg_v_r <= 1'b0;
            reg_a_r <= '0;
            reg_wr_r <= 1'b0;
        end else begin
            cq_r <= cq_nxt;
            open_row_r <= open_row_nxt;
            cnt_r <= cnt_nxt;
            iss_v_r <= iss_v_nxt;
            iss_r <= iss_nxt;
            open_v_r <= open_v_nxt;
            st_r <= st_nxt;
            reg_v_r <= reg_v_nxt;
            reg_a_r <= reg_a_nxt;
            reg_wr_r <= reg_wr_nxt;
        end
    end

    assign o_issue_valid = iss_v_r;
    assign o_issue = iss_r;
    assign o_reg_valid = reg_v_r;
    assign o_reg_addr = reg_a_r;
    assign o_reg_wr = reg_wr_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    a_map_col_low: assert property (
        i_cmd_valid && i_page_words_sel == PAGE_256 |-> map_w.col[7:0] == i_cmd.addr[8:1])
        else $error("column misplaced");
    a_row_width_max: assert property (
        i_internal_bank_count_sel == BANKS_8 && i_page_words_sel == PAGE_2048 |-> map_w.row[13:12] == 2'h0)
        else $error("row too wide");
    a_keep_open_row: assert property (
        load && dec_v && take_mem |=> open_v_r[iss_r.bank] && open_row_r[iss_r.bank] == iss_r.row)
        else $error("row not left open");
    a_pre_only_conflict: assert property (
        load && take_mem && dec.need_pre |-> open_v_r[dec.bank] && open_row_r[dec.bank] != dec.row)
        else $error("needless precharge");
    a_cmd_depth_cap: assert property (
        cnt_r == 3'(CQ_DEPTH) |-> !push ##1 cnt_r >= 3'(CQ_DEPTH - 1))
        else $error("command queue overrun");
    a_must_ref_first: assert property (
        load && must |=> iss_v_r && iss_r.kind == DDRS_K_REF)
        else $error("must refresh late");
    a_read_full_hold: assert property (
        load && rd_full |=> !(iss_v_r && iss_r.kind == DDRS_K_READ))
        else $error("read with fifo full");
    a_write_oldest: assert property (
        load && take_mem && dec.kind == DDRS_K_WRITE |-> elig_old[sel_idx])
        else $error("write out of order");
    a_read_pass_ok: assert property (
        load && take_mem && dec.kind == DDRS_K_READ |-> elig_rd[sel_idx])
        else $error("illegal read overtake");
    a_open_row_pref: assert property (
        load && take_mem && dec.kind == DDRS_K_READ && rd_hit_any |-> hit[sel_idx])
        else $error("open-row read skipped");

    c_read_issue: cover property (load && dec_v && dec.kind == DDRS_K_READ);
    c_write_issue: cover property (load && dec_v && dec.kind == DDRS_K_WRITE);
    c_ref_issue: cover property (load && dec_v && dec.kind == DDRS_K_REF);
    c_read_overtake: cover property (load && take_mem && dec.kind == DDRS_K_READ && !elig_old[sel_idx]);
endmodule

//--- verification/ddrs_mem_model.sv
`timescale 1ns/100ps
// ====================
// sdram side
module ddrs_mem_model
    import ddrs_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // bench control
    input wire logic i_stall,
    input wire logic i_push,
    // issue and write data
    input wire logic i_issue_valid,
    output logic o_issue_ready,
    input wire logic i_wd_valid,
    output logic o_wd_take,
    // read data
    output logic o_rd_valid,
    output logic [ddrs_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    logic [ddrs_pkg::DATA_W-1:0] seq_r;
    logic [ddrs_pkg::DATA_W-1:0] seq_nxt;
    // ====================
    // answers
    assign o_issue_ready = i_issue_valid && !i_stall;
    assign o_wd_take = i_wd_valid && !i_stall;
    // read data, inverse when idle
    assign o_rd_valid = i_push;
    assign o_rd_data = i_push ? seq_r : ~seq_r;
    always_comb begin
        seq_nxt = (i_push && i_rd_ready) ? seq_r + 64'h1 : seq_r;
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seq_r <= '0;
        end else begin
            seq_r <= seq_nxt;
        end
    end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/100ps
// ====================
// scheduler bench
module tb_top;
    import ddrs_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [1:0] i_internal_bank_count_sel = 2'h3;
    logic [1:0] i_page_words_sel = 2'h0;
    logic [3:0] i_ref_backlog = 4'h0;
    logic i_sr_req = 1'b0;
    logic i_cmd_valid = 1'b0;
    ddrs_req_s i_cmd = '0;
    logic i_wd_valid = 1'b0;
    logic [DATA_W-1:0] i_wd_data = '0;
    logic i_rd_ready = 1'b0;
    logic stall = 1'b0;
    logic push = 1'b0;
    logic o_cmd_ready, o_reg_valid, o_reg_wr, o_wd_ready, o_mem_wd_valid, i_mem_wd_take, i_mem_rd_valid;
    logic o_mem_rd_ready, o_rd_valid, o_issue_valid, i_issue_ready;
    logic [31:0] o_reg_addr;
    logic [DATA_W-1:0] o_mem_wd_data, i_mem_rd_data, o_rd_data;
    ddrs_issue_s o_issue, last;
    logic [63:0] hist;
    int ntaken, miscompares, checked, cycles;

    always #2.5 i_core_clk = ~i_core_clk;

    ddrs_sched i_dut (.i_core_clk, .i_arst_n, .i_internal_bank_count_sel, .i_page_words_sel, .i_ref_backlog,
        .i_sr_req, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_reg_valid, .o_reg_addr, .o_reg_wr, .i_wd_valid,
        .i_wd_data, .o_wd_ready, .o_mem_wd_valid, .o_mem_wd_data, .i_mem_wd_take, .i_mem_rd_valid,
        .i_mem_rd_data, .o_mem_rd_ready, .o_rd_valid, .o_rd_data, .i_rd_ready, .o_issue_valid, .o_issue,
        .i_issue_ready);
    ddrs_mem_model i_mem (.i_core_clk, .i_arst_n, .i_stall(stall), .i_push(push), .i_issue_valid(o_issue_valid),
        .o_issue_ready(i_issue_ready), .i_wd_valid(o_mem_wd_valid), .o_wd_take(i_mem_wd_take),
        .o_rd_valid(i_mem_rd_valid), .o_rd_data(i_mem_rd_data), .i_rd_ready(o_mem_rd_ready));

    // ====================
    // issue log
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hist <= '0;
            ntaken <= 0;
        end else if (o_issue_valid && i_issue_ready) begin
            hist <= {hist[59:0], o_issue.kind[1] ? {2'h0, o_issue.kind} : {o_issue.mst, o_issue.kind}};
            ntaken <= ntaken + 1;
            last <= o_issue;
        end
    end

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    // ====================
    // common tasks
    task automatic close_out();
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic do_reset();
        i_arst_n <= 1'b0;
        i_internal_bank_count_sel <= 2'h3;
        i_page_words_sel <= 2'h0;
        repeat (12) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
    endtask

    // k: wr, prio, mst
    task automatic send(input logic [31:0] a, input logic [5:0] k, input logic r);
        i_cmd_valid <= 1'b1;
        i_cmd <= ddrs_req_s'({a, k, 1'b0, r});
        do @(negedge i_core_clk); while (o_cmd_ready !== 1'b1);
        @(posedge i_core_clk);
    endtask

    task automatic wait_n(input int n);
        repeat (200) begin
            if (ntaken >= n) break;
            @(posedge i_core_clk);
        end
        @(negedge i_core_clk);
    endtask

    // one take; backlog drops first
    task automatic take1();
        logic r;
        @(negedge i_core_clk);
        r = o_issue_valid && o_issue.kind == DDRS_K_REF;
        @(posedge i_core_clk);
        stall <= 1'b0;
        if (r) begin
            i_ref_backlog <= i_ref_backlog - 4'h1;
        end
        @(posedge i_core_clk);
        stall <= 1'b1;
    endtask

    function automatic logic [29:0] map_exp(input logic [31:0] a, input int b, input int p);
        int ncb;
        int nrb;
        ncb = 8 + p;
        nrb = (p == 3 && b >= 2) ? 15 - b : 14;
        return {14'((a >> (1 + ncb + b)) & ((32'h1 << nrb) - 1)), 3'((a >> (1 + ncb)) & ((32'h1 << b) - 1)),
            11'((a >> 1) & ((32'h1 << ncb) - 1)), a[0] ? 2'h2 : 2'h1};
    endfunction

    // ====================
    // scenarios
    task automatic t_map();
        logic [31:0] a;
        for (int b = 0; b < 4; b++) begin
            for (int p = 0; p < 8; p++) begin
                a = 32'hF5A3_CFFE + 32'(p % 2);
                i_internal_bank_count_sel <= 2'(b);
                i_page_words_sel <= 2'(p / 2);
                send(a, 6'h00, 1'b0);
                i_cmd_valid <= 1'b0;
                wait_n(ntaken + 1);
                chk("map", 64'(map_exp(a, b, p / 2)), 64'({last.row, last.bank, last.col, last.be}));
                @(posedge i_core_clk);
            end
        end
    endtask

    task automatic t_open();
        logic [31:0] a[6] = '{32'h40, 32'h44, 32'h240, 32'h1040, 32'h244, 32'h40};
        logic [1:0] e[6] = '{2'h1, 2'h0, 2'h1, 2'h3, 2'h0, 2'h3};
        do_reset();
        foreach (a[i]) begin
            send(a[i], 6'h00, 1'b0);
            i_cmd_valid <= 1'b0;
            wait_n(i + 1);
            chk("open rows", 64'(e[i]), 64'({last.need_pre, last.need_act}));
            @(posedge i_core_clk);
        end
    endtask

    task automatic pair(input logic [31:0] a0, input logic [5:0] k0, input logic [31:0] a1, input logic [5:0] k1,
        input logic [11:0] e);
        do_reset();
        stall <= 1'b1;
        send(32'h0, 6'h03, 1'b0);
        send(a0, k0, 1'b0);
        send(a1, k1, 1'b0);
        i_cmd_valid <= 1'b0;
        stall <= 1'b0;
        wait_n(3);
        repeat (4) @(negedge i_core_clk);
        chk("issue order", 64'(e), hist);
    endtask

    task automatic t_depth();
        int n;
        do_reset();
        stall <= 1'b1;
        i_wd_valid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            i_wd_data <= 64'(n);
            @(negedge i_core_clk);
            if (o_wd_ready !== 1'b1) break;
            @(posedge i_core_clk);
        end
        @(posedge i_core_clk);
        i_wd_valid <= 1'b0;
        stall <= 1'b0;
        chk("write fifo depth", 64'd11, 64'(n));
        for (int k = 0; k < 11; k++) begin
            @(negedge i_core_clk);
            chk("write data", 64'(k), o_mem_wd_valid === 1'b1 ? o_mem_wd_data : ~64'(k));
            @(posedge i_core_clk);
        end
        stall <= 1'b1;
        send(32'h0, 6'h00, 1'b0);
        for (n = 0; n < 40; n++) begin
            @(negedge i_core_clk);
            if (o_cmd_ready !== 1'b1) break;
            @(posedge i_core_clk);
        end
        chk("command fifo depth", 64'd7, 64'(n));
        @(posedge i_core_clk);
        stall <= 1'b0;
        send(32'h0, 6'h00, 1'b0);
        send(32'h40, 6'h20, 1'b1);
        i_cmd_valid <= 1'b0;
        @(negedge i_core_clk);
        chk("register access", {30'h0, 2'h3, 32'h40}, {30'h0, o_reg_valid, o_reg_wr, o_reg_addr});
        @(negedge i_core_clk);
        chk("register pulse", 64'h0, 64'(o_reg_valid));
        wait_n(9);
        repeat (4) @(negedge i_core_clk);
        chk("drained", 64'd9, 64'(ntaken));
    endtask

    task automatic t_rdfull();
        int n;
        do_reset();
        push <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge i_core_clk);
            if (o_mem_rd_ready !== 1'b1) break;
            @(posedge i_core_clk);
        end
        @(posedge i_core_clk);
        push <= 1'b0;
        chk("read fifo depth", 64'd17, 64'(n));
        send(32'h2000, 6'h0A, 1'b0);
        send(32'h800, 6'h29, 1'b0);
        i_cmd_valid <= 1'b0;
        wait_n(1);
        chk("full read fifo", 64'h5, hist);
        @(posedge i_core_clk);
        i_rd_ready <= 1'b1;
        for (int k = 0; k < 17; k++) begin
            @(negedge i_core_clk);
            chk("read data", 64'(k), o_rd_valid === 1'b1 ? o_rd_data : ~64'(k));
            @(posedge i_core_clk);
        end
        i_rd_ready <= 1'b0;
        wait_n(2);
        chk("read after drain", 64'h58, hist);
    endtask

    task automatic t_ref();
        do_reset();
        stall <= 1'b1;
        send(32'h0, 6'h03, 1'b0);
        send(32'h2000, 6'h00, 1'b0);
        send(32'h4000, 6'h21, 1'b0);
        i_cmd_valid <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_ref_backlog <= 4'hC;
        repeat (16) take1();
        chk("refresh order", 64'h0C30333353333333, hist);
        i_sr_req <= 1'b1;
        repeat (2) take1();
        chk("self refresh", 64'hC303333533333332, hist);
    endtask

    initial begin
        do_reset();
        t_map();
        t_open();
        pair(32'h800, 6'h28, 32'h2000, 6'h08, 12'hC01);
        pair(32'h800, 6'h28, 32'h810, 6'h1C, 12'hC10);
        pair(32'h800, 6'h34, 32'h2000, 6'h08, 12'hC10);
        pair(32'h800, 6'h29, 32'h810, 6'h0A, 12'hC85);
        pair(32'h2000, 6'h04, 32'h4000, 6'h15, 12'hC40);
        pair(32'h2000, 6'h0C, 32'h4000, 6'h0D, 12'hC04);
        pair(32'h1000, 6'h0C, 32'h0040, 6'h0D, 12'hC40);
        pair(32'h800, 6'h39, 32'h2000, 6'h0A, 12'hC58);
        t_depth();
        t_rdfull();
        t_ref();
        close_out();
    end
endmodule
